// [hw/flash_block_protect_config.sv]
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
module flash_block_protect_config #(
  parameter flash_protect_pkg::mem_size_t MEM_SIZE =
    flash_protect_pkg::MEM_64K
) (
  input  wire logic                       mclk,
  input  wire logic                       nrst,
  input  wire logic                       clk_en,
  input  wire logic [23:0]                reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output      logic [7:0]                 reg_rdata,
  input  wire logic [23:0]                flash_addr,
  input  wire logic                       flash_req,
  input  wire logic                       flash_write,
  input  wire logic                       flash_ext,
  output      logic                       flash_grant,
  output      logic                       flash_deny,
  output      logic                       boot_protected,
  output      logic [3:0]                 block_wr_protected
);
  import flash_protect_pkg::*;

  // Only the four sizes have a block map; anything else is refused
  if (MEM_SIZE != MEM_16K && MEM_SIZE != MEM_32K &&
      MEM_SIZE != MEM_48K && MEM_SIZE != MEM_64K) begin : g_bad_size
    $error("flash_block_protect_config: bad memory size");
  end

  // ****************************************
  // Configuration bytes
  // ****************************************
  logic [7:0] boot_cfg_reg;
  logic [7:0] boot_cfg_next;
  logic [7:0] wrp_cfg_reg;
  logic [7:0] wrp_cfg_next;
  logic [7:0] rdata_reg;
  logic [7:0] rdata_next;

  // Writes can only clear bits: AND with current value, never set
  always_comb begin
    boot_cfg_next = boot_cfg_reg;
    wrp_cfg_next  = wrp_cfg_reg;
    if (reg_wr && reg_addr == BOOT_CFG_ADDR) begin
      boot_cfg_next = boot_cfg_reg & reg_wdata & BOOT_CFG_MASK;
    end else if (reg_wr && reg_addr == WRPROT_CFG_ADDR) begin
      wrp_cfg_next = wrp_cfg_reg & reg_wdata & WRPROT_CFG_MASK;
    end
  end

  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd && reg_addr == BOOT_CFG_ADDR) begin
      rdata_next = boot_cfg_reg & BOOT_CFG_MASK;
    end else if (reg_rd && reg_addr == WRPROT_CFG_ADDR) begin
      rdata_next = wrp_cfg_reg & WRPROT_CFG_MASK;
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      boot_cfg_reg <= BOOT_CFG_RESET;
      wrp_cfg_reg  <= WRPROT_CFG_RESET;
    end else if (clk_en) begin
      boot_cfg_reg <= boot_cfg_next;
      wrp_cfg_reg  <= wrp_cfg_next;
    end
  end

  // Read data stand for one cycle only, then fall back to zero
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 8'h00;
    end else if (clk_en) begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************
  // Range decode
  // ****************************************
  logic        large_part;
  logic [23:0] blk_lo [4];
  logic [23:0] blk_hi [4];
  logic [3:0]  blk_hit;
  logic        boot_hit;

  // Small and large parts use different block maps
  assign large_part = (MEM_SIZE == MEM_48K) ||
                      (MEM_SIZE == MEM_64K);

  always_comb begin
    if (large_part) begin
      blk_lo[0] = LG_B0_LO;
      blk_hi[0] = LG_B0_HI;
      blk_lo[1] = LG_B1_LO;
      blk_hi[1] = LG_B1_HI;
      blk_lo[2] = LG_B2_LO;
      blk_hi[2] = LG_B2_HI;
      blk_lo[3] = LG_B3_LO;
      blk_hi[3] = LG_B3_HI;
    end else begin
      blk_lo[0] = SM_B0_LO;
      blk_hi[0] = SM_B0_HI;
      blk_lo[1] = SM_B1_LO;
      blk_hi[1] = SM_B1_HI;
      blk_lo[2] = SM_B2_LO;
      blk_hi[2] = SM_B2_HI;
      blk_lo[3] = SM_B3_LO;
      blk_hi[3] = SM_B3_HI;
    end
  end

  range_match #(.AW(24)) u_boot (
    .addr (flash_addr),
    .lo   (BOOT_LO),
    .hi   (BOOT_HI),
    .hit  (boot_hit)
  );

  for (genvar i = 0; i < 4; i++) begin : g_blk
    range_match #(.AW(24)) u_blk (
      .addr (flash_addr),
      .lo   (blk_lo[i]),
      .hi   (blk_hi[i]),
      .hit  (blk_hit[i])
    );
  end

  // ****************************************
  // Access gating
  // ****************************************
  logic [3:0] wrp_active;
  logic       boot_cp;
  logic       wr_blocked;
  logic       rd_blocked;
  logic       grant_reg;
  logic       grant_next;
  logic       deny_reg;
  logic       deny_next;

  // Write protect bits only affect writes; code protect only external reads
  assign wrp_active = ~wrp_cfg_reg[3:0];
  assign boot_cp    = ~boot_cfg_reg[BOOT_CP_BIT];
  assign wr_blocked = |(blk_hit & wrp_active);
  assign rd_blocked = boot_hit && boot_cp && flash_ext;

  always_comb begin
    grant_next = 1'b0;
    deny_next  = 1'b0;
    if (flash_req) begin
      if (flash_write ? wr_blocked : rd_blocked) begin
        deny_next = 1'b1;
      end else begin
        grant_next = 1'b1;
      end
    end
  end

  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      grant_reg <= 1'b0;
      deny_reg  <= 1'b0;
    end else if (clk_en) begin
      grant_reg <= grant_next;
      deny_reg  <= deny_next;
    end
  end

  assign flash_grant        = grant_reg;
  assign flash_deny         = deny_reg;
  assign boot_protected     = boot_cp;
  assign block_wr_protected = wrp_active;

  // ****************************************
  // Checks
  // ****************************************
  // Address windows are rebuilt from the constants, not from the decoder,
  // so a wrong entry in the block map table shows up here
  default clocking cb_chk @(posedge mclk);
  endclocking

  default disable iff (!nrst);

  sequence s_refused;
    flash_deny && !flash_grant;
  endsequence

  sequence s_allowed;
    flash_grant && !flash_deny;
  endsequence

  sequence s_wr_blk3;
    clk_en && flash_req && flash_write && large_part &&
      flash_addr >= LG_B3_LO && flash_addr <= LG_B3_HI &&
      !wrp_cfg_reg[BLK3_WP_BIT];
  endsequence

  sequence s_wr_blk2_small;
    clk_en && flash_req && flash_write && !large_part &&
      flash_addr >= SM_B2_LO && flash_addr <= SM_B2_HI &&
      !wrp_cfg_reg[BLK2_WP_BIT];
  endsequence

  sequence s_wr_blk2_large;
    clk_en && flash_req && flash_write && large_part &&
      flash_addr >= LG_B2_LO && flash_addr <= LG_B2_HI &&
      !wrp_cfg_reg[BLK2_WP_BIT];
  endsequence

  sequence s_boot_ext_read;
    clk_en && flash_req && !flash_write && flash_ext &&
      flash_addr <= BOOT_HI && !boot_cfg_reg[BOOT_CP_BIT];
  endsequence

  a_blk3_write_deny: assert property (
    s_wr_blk3 |=> s_refused)
    else $error("block 3 write not refused");

  a_blk3_write_open: assert property (
    clk_en && flash_req && flash_write && large_part &&
    flash_addr >= LG_B3_LO && flash_addr <= LG_B3_HI &&
    wrp_cfg_reg[BLK3_WP_BIT] |=> s_allowed)
    else $error("open block 3 write refused");

  a_blk2_write_deny: assert property (
    s_wr_blk2_small |=> s_refused)
    else $error("block 2 write not refused");

  a_blk2_large_deny: assert property (
    s_wr_blk2_large |=> s_refused)
    else $error("large block 2 write not refused");

  a_exec_not_blocked: assert property (
    clk_en && flash_req && !flash_write && !flash_ext |=> s_allowed)
    else $error("internal fetch refused");

  a_boot_read_deny: assert property (
    s_boot_ext_read |=> s_refused)
    else $error("protected boot read allowed");

  a_boot_read_open: assert property (
    clk_en && flash_req && !flash_write && flash_ext &&
    flash_addr <= BOOT_HI && boot_cfg_reg[BOOT_CP_BIT] |=> s_allowed)
    else $error("open boot read refused");

  // Bits may fall from one to zero, never rise, outside reset
  a_no_set_back: assert property (
    (~$past(wrp_cfg_reg) & wrp_cfg_reg) == 8'h00)
    else $error("protect bit set back");

  a_boot_no_set: assert property (
    !$past(boot_cfg_reg[BOOT_CP_BIT]) |-> !boot_cfg_reg[BOOT_CP_BIT])
    else $error("boot protect set back");

  a_ones_write_kept: assert property (
    clk_en && reg_wr && reg_wdata == 8'hff |=>
    $stable(wrp_cfg_reg) && $stable(boot_cfg_reg))
    else $error("all-ones write changed a byte");

  a_frozen_cfg: assert property (
    !clk_en |=> $stable(wrp_cfg_reg) && $stable(boot_cfg_reg))
    else $error("byte changed while frozen");

  a_unimpl_zero: assert property (
    clk_en && reg_rd && reg_addr == BOOT_CFG_ADDR |=>
    (reg_rdata & ~BOOT_CFG_MASK) == 8'h00)
    else $error("unimplemented boot bit reads one");

  a_unimpl_zero_wp: assert property (
    clk_en && reg_rd && reg_addr == WRPROT_CFG_ADDR |=>
    (reg_rdata & ~WRPROT_CFG_MASK) == 8'h00)
    else $error("unimplemented block bit reads one");

  a_unmapped_zero: assert property (
    clk_en && reg_rd && reg_addr != BOOT_CFG_ADDR &&
    reg_addr != WRPROT_CFG_ADDR |=> reg_rdata == 8'h00)
    else $error("unmapped read not zero");

  // A read is granted unless it is an outside read of a locked boot block:
  // the write-protect bits must never leak into reads
  a_wrp_separate: assert property (
    clk_en && flash_req && !flash_write &&
    !(flash_ext && flash_addr <= BOOT_HI && !boot_cfg_reg[BOOT_CP_BIT])
    |=> s_allowed)
    else $error("block write protect gated a read");

  a_wrp_keeps_boot: assert property (
    clk_en && reg_wr && reg_addr == WRPROT_CFG_ADDR |=>
    $stable(boot_cfg_reg))
    else $error("block byte write changed boot byte");

  a_small_map: assert property (
    clk_en && flash_req && flash_write && !large_part &&
    flash_addr >= LG_B3_LO && flash_addr <= LG_B3_HI |=> s_allowed)
    else $error("small part refused unmapped range");

  a_large_map: assert property (
    clk_en && flash_req && flash_write && large_part &&
    flash_addr >= SM_B2_LO && flash_addr <= SM_B2_HI &&
    wrp_cfg_reg[BLK1_WP_BIT] |=> s_allowed)
    else $error("large part used small map");

  // Every taken request gets exactly one answer, and nothing else does
  a_one_answer: assert property (
    clk_en && flash_req |=> flash_grant ^ flash_deny)
    else $error("request without a single answer");

  a_no_stray_answer: assert property (
    clk_en && !flash_req |=> !flash_grant && !flash_deny)
    else $error("answer without a request");

endmodule

// [hw/flash_protect_pkg.sv]
package flash_protect_pkg;

  // ****************************************
  // Register map
  // ****************************************
  localparam logic [23:0] BOOT_CFG_ADDR  = 24'h30_0009;
  localparam logic [23:0] WRPROT_CFG_ADDR = 24'h30_000a;

  // ****************************************
  // Field positions
  // ****************************************
  localparam int BOOT_CP_BIT = 6;
  localparam int BLK3_WP_BIT = 3;
  localparam int BLK2_WP_BIT = 2;
  localparam int BLK1_WP_BIT = 1;
  localparam int BLK0_WP_BIT = 0;

  // Implemented-bit masks; everything else reads as zero
  localparam logic [7:0] BOOT_CFG_MASK   = 8'h40;
  localparam logic [7:0] WRPROT_CFG_MASK = 8'h0f;

  // ****************************************
  // Reset (unprogrammed) values
  // ****************************************
  localparam logic [7:0] BOOT_CFG_RESET   = 8'h40;
  localparam logic [7:0] WRPROT_CFG_RESET = 8'h0f;

  // ****************************************
  // Address ranges
  // ****************************************
  localparam logic [23:0] BOOT_LO      = 24'h00_0000;
  localparam logic [23:0] BOOT_HI      = 24'h00_07ff;
  localparam logic [23:0] SM_B0_LO     = 24'h00_0800;
  localparam logic [23:0] SM_B0_HI     = 24'h00_1fff;
  localparam logic [23:0] SM_B1_LO     = 24'h00_2000;
  localparam logic [23:0] SM_B1_HI     = 24'h00_3fff;
  localparam logic [23:0] SM_B2_LO     = 24'h00_4000;
  localparam logic [23:0] SM_B2_HI     = 24'h00_5fff;
  localparam logic [23:0] SM_B3_LO     = 24'h00_6000;
  localparam logic [23:0] SM_B3_HI     = 24'h00_7fff;
  localparam logic [23:0] LG_B0_LO     = 24'h00_0800;
  localparam logic [23:0] LG_B0_HI     = 24'h00_3fff;
  localparam logic [23:0] LG_B1_LO     = 24'h00_4000;
  localparam logic [23:0] LG_B1_HI     = 24'h00_7fff;
  localparam logic [23:0] LG_B2_LO     = 24'h00_8000;
  localparam logic [23:0] LG_B2_HI     = 24'h00_bfff;
  localparam logic [23:0] LG_B3_LO     = 24'h00_c000;
  localparam logic [23:0] LG_B3_HI     = 24'h00_ffff;

  // ****************************************
  // Memory size variants
  // ****************************************
  typedef enum logic [1:0] {
    MEM_16K,
    MEM_32K,
    MEM_48K,
    MEM_64K
  } mem_size_t;

  typedef enum logic [1:0] {
    OP_IDLE,
    OP_CHECK,
    OP_GO
  } op_state_t;

endpackage

// [hw/range_match.sv]
`timescale 1ns/1ps
module range_match #(
  parameter int AW = 24
) (
  input  wire logic [AW-1:0] addr,
  input  wire logic [AW-1:0] lo,
  input  wire logic [AW-1:0] hi,
  output      logic          hit
);
  // Narrower buses cannot reach the top block of the larger map
  if (AW < 16) begin : g_bad_width
    $error("range_match: address width too small");
  end

  assign hit = (addr >= lo) && (addr <= hi);
endmodule

// [sim/tb_flash_block_protect_config.sv]
`timescale 1ns/1ps
module tb_flash_block_protect_config;
  import flash_protect_pkg::*;

  // ****************************************
  // Stimulus and observed signals
  // ****************************************
  logic        mclk;
  logic        nrst;
  logic        clk_en;
  logic [23:0] reg_addr;
  logic [7:0]  reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [23:0] flash_addr;
  logic        flash_req;
  logic        flash_write;
  logic        flash_ext;
  logic [7:0]  rd_lg;
  logic [7:0]  rd_sm;
  logic [1:0]  ans_lg;
  logic [1:0]  ans_sm;
  logic        bp_lg;
  logic        bp_sm;
  logic [3:0]  wp_lg;
  logic [3:0]  wp_sm;
  int          num_errors;
  int          samples_checked;

  // Both map variants share one bus so one stimulus covers both
  flash_block_protect_config #(.MEM_SIZE(MEM_64K)) dut (
    .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rd_lg), .flash_addr(flash_addr), .flash_req(flash_req),
    .flash_write(flash_write), .flash_ext(flash_ext),
    .flash_grant(ans_lg[1]), .flash_deny(ans_lg[0]),
    .boot_protected(bp_lg), .block_wr_protected(wp_lg));
  flash_block_protect_config #(.MEM_SIZE(MEM_32K)) dut_small (
    .mclk(mclk), .nrst(nrst), .clk_en(clk_en), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(rd_sm), .flash_addr(flash_addr), .flash_req(flash_req),
    .flash_write(flash_write), .flash_ext(flash_ext),
    .flash_grant(ans_sm[1]), .flash_deny(ans_sm[0]),
    .boot_protected(bp_sm), .block_wr_protected(wp_sm));

  always #2 mclk = ~mclk;

  // ****************************************
  // Tasks
  // ****************************************
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic reg_write(input logic [23:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge mclk);
    reg_wr    <= 1'b0;
    #1;
  endtask

  // Data stand only in the cycle after the strobe, so sample there
  task automatic reg_read(input logic [23:0] a, input logic [7:0] exp);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge mclk);
    reg_rd   <= 1'b0;
    #1;
    check({rd_lg, rd_sm}, {exp, exp});
  endtask

  // Expected answers are {grant, deny} for the large and small maps
  task automatic access(input logic [23:0] a, input logic wr, input logic ext,
                        input logic [1:0] exp_lg, input logic [1:0] exp_sm);
    @(posedge mclk);
    flash_addr  <= a;
    flash_write <= wr;
    flash_ext   <= ext;
    flash_req   <= 1'b1;
    @(posedge mclk);
    flash_req   <= 1'b0;
    #1;
    check({ans_lg, ans_sm}, {exp_lg, exp_sm});
  endtask

  task automatic print_verdict;
    $display("Comparisons %0d, mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    mclk = 1'b0; nrst = 1'b0; clk_en = 1'b1; reg_addr = 24'h00_0000;
    reg_wdata = 8'h00; reg_wr = 1'b0; reg_rd = 1'b0; flash_req = 1'b0;
    flash_addr = 24'h00_0000; flash_write = 1'b0; flash_ext = 1'b0;
    num_errors = 0; samples_checked = 0;
    repeat (16) @(posedge mclk);
    nrst <= 1'b1;
    reg_read(BOOT_CFG_ADDR, 8'h40);
    reg_read(WRPROT_CFG_ADDR, 8'h0f);
    check({bp_lg, wp_lg, bp_sm, wp_sm}, 10'h000);
    reg_read(24'h30_000b, 8'h00);
    $display("Test reset values done");
    // Frozen clock enable must drop the write
    @(posedge mclk) clk_en <= 1'b0;
    reg_write(WRPROT_CFG_ADDR, 8'h00);
    @(posedge mclk) clk_en <= 1'b1;
    reg_write(24'h30_0008, 8'h00);
    reg_read(WRPROT_CFG_ADDR, 8'h0f);
    reg_write(WRPROT_CFG_ADDR, 8'hfb);
    check({wp_lg, wp_sm}, 8'h44);
    reg_write(WRPROT_CFG_ADDR, 8'hff);
    reg_read(WRPROT_CFG_ADDR, 8'h0b);
    @(posedge mclk);
    #1 check(rd_lg, 8'h00);
    $display("Test clear-only bits done");
    access(24'h00_8000, 1'b1, 1'b0, 2'b01, 2'b10);
    access(24'h00_bfff, 1'b1, 1'b0, 2'b01, 2'b10);
    access(24'h00_4000, 1'b1, 1'b0, 2'b10, 2'b01);
    access(24'h00_5fff, 1'b1, 1'b0, 2'b10, 2'b01);
    access(24'h00_6000, 1'b1, 1'b0, 2'b10, 2'b10);
    access(24'h00_c000, 1'b1, 1'b0, 2'b10, 2'b10);
    access(24'h00_8000, 1'b0, 1'b0, 2'b10, 2'b10);
    access(24'h00_4000, 1'b0, 1'b1, 2'b10, 2'b10);
    $display("Test block 2 protect done");
    reg_write(WRPROT_CFG_ADDR, 8'hf7);
    check({wp_lg, wp_sm}, 8'hcc);
    reg_read(WRPROT_CFG_ADDR, 8'h03);
    access(24'h00_c000, 1'b1, 1'b0, 2'b01, 2'b10);
    access(24'h00_ffff, 1'b1, 1'b0, 2'b01, 2'b10);
    access(24'h00_bfff, 1'b1, 1'b0, 2'b01, 2'b10);
    access(24'h00_c000, 1'b0, 1'b0, 2'b10, 2'b10);
    $display("Test block 3 protect done");
    access(24'h00_0000, 1'b0, 1'b1, 2'b10, 2'b10);
    reg_write(BOOT_CFG_ADDR, 8'hbf);
    check({bp_lg, bp_sm}, 2'b11);
    reg_write(BOOT_CFG_ADDR, 8'hff);
    reg_read(BOOT_CFG_ADDR, 8'h00);
    access(24'h00_0000, 1'b0, 1'b1, 2'b01, 2'b01);
    access(24'h00_07ff, 1'b0, 1'b1, 2'b01, 2'b01);
    access(24'h00_0800, 1'b0, 1'b1, 2'b10, 2'b10);
    access(24'h00_07ff, 1'b0, 1'b0, 2'b10, 2'b10);
    $display("Test boot code protect done");
    print_verdict();
  end

  // Guard against a hang anywhere in the sequence
  initial begin
    #100000;
    num_errors++;
    print_verdict();
  end
endmodule
